// File: lta_pkg.sv
// Purpose: shared constants and types of the analyzer trigger block
// Assumes: probes and the register port share the sample clock
// Notes: register offsets are byte addresses on the register port
// What this block does
// - Units compare probes: == != > >= < <=
// - Don't-care bits only for ==, != and serial
// - Edge operators use the value as bit mask
// - Edge unit fires on any enabled bit edge
// - Serial compare matches pattern bits, first first
// - Serial units probe one signal, binary pattern
// - Serial choice fixed; other settings run-time writable
// - Units and expressions fixed at build time
// - Sixteen expressions, each enabled by software
// - Expressions combine units with boolean and sequences
// - Each stage may need a programmed count
// - Sequence depth and counter width stay fixed
// - Event is AND-all or OR-all of expressions
// - Final counter delays trigger until count reached
// - Samples times triggers must fit trace depth
// - Position: 1/16, 1/2, 15/16 or user index
// - Position given as sample index in window
// - NEXT stage must hold the very next clock
// - Consecutive count breaks on any gap
package lta_pkg;
    localparam int NUM_TU    = 4;
    localparam int TU_W      = 8;
    localparam int NUM_EXPR  = 16;
    localparam int SEQ_DEPTH = 4;
    localparam int CNT_W     = 8;
    localparam int FIN_W     = 16;
    localparam int IDX_W     = 11;
    localparam int ADDR_W    = 10;
    localparam int LEN_W     = 4;
    localparam int STG_W     = 27;

    localparam logic [21:0]       TRACE_DEPTH  = 22'h000400;
    localparam logic [NUM_TU-1:0] SERIAL_UNITS = 4'h8;

    typedef enum logic [2:0] {OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_RISE, OP_FALL} lta_op_e;
    typedef enum logic [1:0] {POS_PRE, POS_CENTER, POS_POST, POS_USER} lta_pos_e;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] A_CTRL     = 10'h000;
    localparam logic [ADDR_W-1:0] A_EXPR_EN  = 10'h004;
    localparam logic [ADDR_W-1:0] A_FINAL    = 10'h008;
    localparam logic [ADDR_W-1:0] A_SPT      = 10'h00C;
    localparam logic [ADDR_W-1:0] A_NTRIG    = 10'h010;
    localparam logic [ADDR_W-1:0] A_POS      = 10'h014;
    localparam logic [ADDR_W-1:0] A_STATUS   = 10'h018;
    localparam logic [ADDR_W-1:0] A_TRIG_CNT = 10'h01C;
    localparam logic [ADDR_W-1:0] A_SER_LEN  = 10'h020;
    localparam logic [ADDR_W-1:0] A_TU_BASE  = 10'h040;
    localparam logic [ADDR_W-1:0] A_TU_END   = 10'h080;
    localparam logic [ADDR_W-1:0] A_STG_BASE = 10'h100;
    localparam logic [ADDR_W-1:0] A_STG_END  = 10'h200;

    // Control bits and fields
    localparam int CTRL_ARM    = 0;
    localparam int CTRL_ALL    = 1;
    localparam int CTRL_FIN_EN = 2;
    localparam int CTRL_CLEAR  = 3;
    localparam int POS_USER_LSB = 16;
    localparam int STG_CNT_LSB = 16;
    localparam int STG_CONSEC  = 24;
    localparam int STG_NEXT    = 25;
    localparam int STG_LAST    = 26;

    // Values after reset
    localparam logic [2:0]       RST_CTRL    = 3'h0;
    localparam logic [FIN_W-1:0] RST_FINAL   = 16'h0001;
    localparam logic [IDX_W-1:0] RST_SPT     = 11'h080;
    localparam logic [IDX_W-1:0] RST_NTRIG   = 11'h001;
    localparam logic [LEN_W-1:0] RST_SER_LEN = 4'h4;
endpackage

// File: lta_trig_unit.sv
`timescale 1ns/1ps
// Purpose: one trigger unit: magnitude, edge or serial compare of its probes
// Assumes: probes already sampled on clock_i
// Notes: a serial unit looks only at probe bit 0 and ignores op_i
module lta_trig_unit #(
    parameter bit SERIAL = 1'b0
) (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      clear_i,
    // Probes and setup
    input  wire logic [lta_pkg::TU_W-1:0]  probe_i,
    input  wire lta_pkg::lta_op_e          op_i,
    input  wire logic [lta_pkg::TU_W-1:0]  value_i,
    input  wire logic [lta_pkg::TU_W-1:0]  care_i,
    input  wire logic [lta_pkg::LEN_W-1:0] ser_len_i,
    // Result
    output logic                           hit_o
);
    import lta_pkg::*;

    logic [TU_W-1:0]  prev_q, prev_d, hist_q, hist_d, hist_now, len_mask;
    logic [LEN_W-1:0] fill_q, fill_d, fill_now;
    logic             match_eq;

    always_comb begin
        prev_d   = probe_i;
        hist_now = {hist_q[TU_W-2:0], probe_i[0]};
        fill_now = (fill_q == LEN_W'(TU_W)) ? fill_q : fill_q + 4'h1;
        hist_d   = clear_i ? '0 : hist_now;
        fill_d   = clear_i ? '0 : fill_now;
        len_mask = ~({TU_W{1'b1}} << ser_len_i);
        match_eq = ((probe_i ^ value_i) & care_i) == '0;
        if (SERIAL) begin
            hit_o = (((hist_now ^ value_i) & care_i & len_mask) == '0) && (fill_now >= ser_len_i);
        end else begin
            case (op_i)
                OP_EQ:   hit_o = match_eq;
                OP_NE:   hit_o = !match_eq;
                OP_GT:   hit_o = probe_i > value_i;
                OP_GE:   hit_o = probe_i >= value_i;
                OP_LT:   hit_o = probe_i < value_i;
                OP_LE:   hit_o = probe_i <= value_i;
                OP_RISE: hit_o = |(probe_i & ~prev_q & value_i);
                default: hit_o = |(~probe_i & prev_q & value_i);
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q <= '0;
            hist_q <= '0;
            fill_q <= '0;
        end else begin
            prev_q <= prev_d;
            hist_q <= hist_d;
            fill_q <= fill_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    edge_any_a: assert property (!SERIAL && op_i == OP_FALL
        && |(~probe_i & $past(probe_i) & value_i) |-> hit_o) else $error("falling edge missed");
    eq_mask_a: assert property (!SERIAL && op_i == OP_EQ && probe_i == (value_i ^ ~care_i)
        |-> hit_o) else $error("don't-care bit not ignored");
    mag_gt_a: assert property (!SERIAL && op_i == OP_GT && !(probe_i > value_i)
        |-> !hit_o) else $error("greater compare wrong");
    serial_seq_a: assert property (SERIAL && ser_len_i == 4'h4 && value_i[3:0] == 4'hB
        && care_i[3:0] == 4'hF && !clear_i && !$past(clear_i) && fill_q >= 4'h3
        && probe_i[0] && $past(probe_i[0]) && !$past(probe_i[0], 2) && $past(probe_i[0], 3)
        |-> hit_o) else $error("serial pattern missed");
endmodule // lta_trig_unit

// File: lta_trigger.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Purpose: trigger engine: units, sequenced expressions, final count, position
// Assumes: probes come from logic on clock_i, which is the sample clock
// Notes: each stage term is a 16-entry truth table indexed by the unit hits
module lta_trigger (
    // Clock and reset
    input  wire logic                                     clock_i,
    input  wire logic                                     arst_n_i,
    // Probes, unit u on bits [u*TU_W +: TU_W]
    input  wire logic [lta_pkg::NUM_TU*lta_pkg::TU_W-1:0] probe_i,
    // Register port
    input  wire logic [lta_pkg::ADDR_W-1:0]               addr_i,
    input  wire logic [31:0]                              wdata_i,
    input  wire logic                                     wr_i,
    input  wire logic                                     rd_i,
    output logic      [31:0]                              rdata_o,
    // Trigger results
    output logic                                          trigger_o,
    output logic      [lta_pkg::IDX_W-1:0]                trig_pos_o,
    output logic                                          done_o
);
    import lta_pkg::*;

    localparam int NSTG = NUM_EXPR * SEQ_DEPTH;

    function automatic logic [CNT_W:0] stage_goal(input logic [STG_W-1:0] w);
        // A count of zero behaves as one
        if (w[STG_CNT_LSB +: CNT_W] == '0) begin
            stage_goal = 9'h001;
        end else begin
            stage_goal = {1'b0, w[STG_CNT_LSB +: CNT_W]};
        end
    endfunction

    function automatic logic term(input logic [STG_W-1:0] w, input logic [NUM_TU-1:0] h);
        term = w[h];
    endfunction

    // Configuration
    logic [2:0]          ctrl_q, ctrl_d;
    logic [NUM_EXPR-1:0] expr_en_q, expr_en_d;
    logic [FIN_W-1:0]    final_q, final_d;
    logic [IDX_W-1:0]    spt_q, spt_d, ntrig_q, ntrig_d, user_q, user_d;
    lta_pos_e            pos_q, pos_d;
    logic [LEN_W-1:0]    ser_len_q, ser_len_d;
    lta_op_e             op_q [NUM_TU];
    lta_op_e             op_d [NUM_TU];
    logic [TU_W-1:0]     val_q [NUM_TU];
    logic [TU_W-1:0]     val_d [NUM_TU];
    logic [TU_W-1:0]     care_q [NUM_TU];
    logic [TU_W-1:0]     care_d [NUM_TU];
    logic [STG_W-1:0]    stg_q [NSTG];
    logic [STG_W-1:0]    stg_d [NSTG];
    logic [31:0]         rdata_q, rdata_d;
    // Engine state
    logic [1:0]          sst_q [NUM_EXPR];
    logic [1:0]          sst_d [NUM_EXPR];
    logic [CNT_W-1:0]    scnt_q [NUM_EXPR];
    logic [CNT_W-1:0]    scnt_d [NUM_EXPR];
    logic [NUM_EXPR-1:0] strict_q, strict_d, sat_q, sat_d, cond, done_seq;
    logic [FIN_W-1:0]    fcnt_q, fcnt_d;
    logic [IDX_W-1:0]    tcnt_q, tcnt_d, trig_pos_q, trig_pos_d, pos_calc;
    logic                trig_q, trig_d, done_q, done_d;
    // Decode and status
    logic [NUM_TU-1:0]   hit;
    logic [1:0]          tu_sel;
    logic [5:0]          stg_sel;
    logic [21:0]         window_prod;
    logic                clear_w, cfg_bad, running, all_ok, any_ok, event_w, fire;

    assign tu_sel      = addr_i[5:4];
    assign stg_sel     = addr_i[7:2];
    assign clear_w     = wr_i && addr_i == A_CTRL && wdata_i[CTRL_CLEAR];
    assign window_prod = 22'(spt_q) * 22'(ntrig_q);
    assign cfg_bad     = window_prod > TRACE_DEPTH || spt_q == '0 || ntrig_q == '0;
    assign running     = ctrl_q[CTRL_ARM] && !done_q && !cfg_bad;

    for (genvar u = 0; u < NUM_TU; u++) begin : g_tu
        lta_trig_unit #(.SERIAL(SERIAL_UNITS[u])) u_tu (
            .clock_i   (clock_i),
            .arst_n_i  (arst_n_i),
            .clear_i   (clear_w),
            .probe_i   (probe_i[u*TU_W +: TU_W]),
            .op_i      (op_q[u]),
            .value_i   (val_q[u]),
            .care_i    (care_q[u]),
            .ser_len_i (ser_len_q),
            .hit_o     (hit[u])
        );
    end

    // Register writes and reads
    always_comb begin
        ctrl_d    = ctrl_q;
        expr_en_d = expr_en_q;
        final_d   = final_q;
        spt_d     = spt_q;
        ntrig_d   = ntrig_q;
        user_d    = user_q;
        pos_d     = pos_q;
        ser_len_d = ser_len_q;
        op_d      = op_q;
        val_d     = val_q;
        care_d    = care_q;
        stg_d     = stg_q;
        rdata_d   = '0;
        if (wr_i) begin
            if (addr_i == A_CTRL) begin
                ctrl_d = wdata_i[2:0];
            end else if (addr_i == A_EXPR_EN) begin
                expr_en_d = wdata_i[NUM_EXPR-1:0];
            end else if (addr_i == A_FINAL) begin
                final_d = wdata_i[FIN_W-1:0];
            end else if (addr_i == A_SPT) begin
                spt_d = wdata_i[IDX_W-1:0];
            end else if (addr_i == A_NTRIG) begin
                ntrig_d = wdata_i[IDX_W-1:0];
            end else if (addr_i == A_POS) begin
                pos_d  = lta_pos_e'(wdata_i[1:0]);
                user_d = wdata_i[POS_USER_LSB +: IDX_W];
            end else if (addr_i == A_SER_LEN) begin
                ser_len_d = wdata_i[LEN_W-1:0];
            end else if (addr_i >= A_TU_BASE && addr_i < A_TU_END) begin
                if (addr_i[3:2] == 2'h0 && !SERIAL_UNITS[tu_sel]) begin
                    op_d[tu_sel] = lta_op_e'(wdata_i[2:0]);
                end else if (addr_i[3:2] == 2'h1) begin
                    val_d[tu_sel] = wdata_i[TU_W-1:0];
                end else if (addr_i[3:2] == 2'h2) begin
                    care_d[tu_sel] = wdata_i[TU_W-1:0];
                end
            end else if (addr_i >= A_STG_BASE && addr_i < A_STG_END) begin
                stg_d[stg_sel] = wdata_i[STG_W-1:0];
            end
        end
        if (rd_i) begin
            if (addr_i == A_CTRL) begin
                rdata_d = 32'(ctrl_q);
            end else if (addr_i == A_EXPR_EN) begin
                rdata_d = 32'(expr_en_q);
            end else if (addr_i == A_FINAL) begin
                rdata_d = 32'(final_q);
            end else if (addr_i == A_SPT) begin
                rdata_d = 32'(spt_q);
            end else if (addr_i == A_NTRIG) begin
                rdata_d = 32'(ntrig_q);
            end else if (addr_i == A_POS) begin
                rdata_d = {5'h00, user_q, 14'h0000, pos_q};
            end else if (addr_i == A_STATUS) begin
                rdata_d = 32'({cfg_bad, done_q, sat_q});
            end else if (addr_i == A_TRIG_CNT) begin
                rdata_d = 32'(tcnt_q);
            end else if (addr_i == A_SER_LEN) begin
                rdata_d = 32'(ser_len_q);
            end else if (addr_i >= A_TU_BASE && addr_i < A_TU_END) begin
                if (addr_i[3:2] == 2'h0) begin
                    rdata_d = 32'(op_q[tu_sel]);
                end else if (addr_i[3:2] == 2'h1) begin
                    rdata_d = 32'(val_q[tu_sel]);
                end else if (addr_i[3:2] == 2'h2) begin
                    rdata_d = 32'(care_q[tu_sel]);
                end
            end else if (addr_i >= A_STG_BASE && addr_i < A_STG_END) begin
                rdata_d = 32'(stg_q[stg_sel]);
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q    <= RST_CTRL;
            expr_en_q <= '0;
            final_q   <= RST_FINAL;
            spt_q     <= RST_SPT;
            ntrig_q   <= RST_NTRIG;
            user_q    <= '0;
            pos_q     <= POS_PRE;
            ser_len_q <= RST_SER_LEN;
            rdata_q   <= '0;
            for (int u = 0; u < NUM_TU; u++) begin
                op_q[u]   <= OP_EQ;
                val_q[u]  <= '0;
                care_q[u] <= '1;
            end
            for (int s = 0; s < NSTG; s++) begin
                stg_q[s] <= '0;
            end
        end else begin
            ctrl_q    <= ctrl_d;
            expr_en_q <= expr_en_d;
            final_q   <= final_d;
            spt_q     <= spt_d;
            ntrig_q   <= ntrig_d;
            user_q    <= user_d;
            pos_q     <= pos_d;
            ser_len_q <= ser_len_d;
            rdata_q   <= rdata_d;
            op_q      <= op_d;
            val_q     <= val_d;
            care_q    <= care_d;
            stg_q     <= stg_d;
        end
    end

    // Sequence engine, event forming, final count and position
    always_comb begin
        logic [STG_W-1:0] w;
        w        = '0;
        sst_d    = sst_q;
        scnt_d   = scnt_q;
        strict_d = strict_q;
        done_seq = '0;
        cond     = '0;
        for (int e = 0; e < NUM_EXPR; e++) begin
            w       = stg_q[e*SEQ_DEPTH + int'(sst_q[e])];
            cond[e] = term(w, hit);
            if (clear_w || !running) begin
                sst_d[e]    = '0;
                scnt_d[e]   = '0;
                strict_d[e] = 1'b0;
            end else if (cond[e]) begin
                if ({1'b0, scnt_q[e]} + 9'h001 >= stage_goal(w)) begin
                    scnt_d[e] = '0;
                    if (w[STG_LAST] || sst_q[e] == 2'(SEQ_DEPTH-1)) begin
                        done_seq[e] = 1'b1;
                        sst_d[e]    = '0;
                        strict_d[e] = 1'b0;
                    end else begin
                        sst_d[e]    = sst_q[e] + 2'h1;
                        strict_d[e] = stg_q[e*SEQ_DEPTH + int'(sst_q[e]) + 1][STG_NEXT];
                    end
                end else begin
                    scnt_d[e]   = scnt_q[e] + 8'h01;
                    strict_d[e] = w[STG_CONSEC];
                end
            end else if (strict_q[e]) begin
                sst_d[e]    = '0;
                scnt_d[e]   = '0;
                strict_d[e] = 1'b0;
            end
        end
        all_ok  = (&(sat_q | ~expr_en_q)) && (|expr_en_q);
        any_ok  = |(sat_q & expr_en_q);
        event_w = running && (ctrl_q[CTRL_ALL] ? all_ok : any_ok);
        // A sequence that completes as the event clears still counts
        sat_d   = clear_w ? '0 : ((event_w ? '0 : sat_q) | done_seq);
        case (pos_q)
            POS_PRE:    pos_calc = spt_q >> 4;
            POS_CENTER: pos_calc = spt_q >> 1;
            POS_POST:   pos_calc = spt_q - (spt_q >> 4);
            default:    pos_calc = (user_q < spt_q) ? user_q : spt_q - 11'h001;
        endcase
        fcnt_d = fcnt_q;
        fire   = 1'b0;
        if (clear_w) begin
            fcnt_d = '0;
        end else if (event_w) begin
            if (ctrl_q[CTRL_FIN_EN] && {1'b0, fcnt_q} + 17'h00001 < {1'b0, final_q}) begin
                fcnt_d = fcnt_q + 16'h0001;
            end else begin
                fcnt_d = '0;
                fire   = 1'b1;
            end
        end
        trig_d     = fire;
        trig_pos_d = fire ? pos_calc : trig_pos_q;
        tcnt_d     = clear_w ? '0 : (fire ? tcnt_q + 11'h001 : tcnt_q);
        done_d     = clear_w ? 1'b0 : (done_q || (fire && tcnt_q + 11'h001 >= ntrig_q));
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int e = 0; e < NUM_EXPR; e++) begin
                sst_q[e]  <= '0;
                scnt_q[e] <= '0;
            end
            strict_q   <= '0;
            sat_q      <= '0;
            fcnt_q     <= '0;
            tcnt_q     <= '0;
            trig_pos_q <= '0;
            trig_q     <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            sst_q      <= sst_d;
            scnt_q     <= scnt_d;
            strict_q   <= strict_d;
            sat_q      <= sat_d;
            fcnt_q     <= fcnt_d;
            tcnt_q     <= tcnt_d;
            trig_pos_q <= trig_pos_d;
            trig_q     <= trig_d;
            done_q     <= done_d;
        end
    end

    assign rdata_o    = rdata_q;
    assign trigger_o  = trig_q;
    assign trig_pos_o = trig_pos_q;
    assign done_o     = done_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    next_fail_a: assert property (running && !clear_w && strict_q[0] && !cond[0]
        |=> sst_q[0] == 2'h0 && scnt_q[0] == '0) else $error("failed NEXT did not restart");
    count_step_a: assert property (running && !clear_w && cond[0]
        && {1'b0, scnt_q[0]} + 9'h001 < stage_goal(stg_q[int'(sst_q[0])])
        |=> scnt_q[0] == $past(scnt_q[0]) + 8'h01 && $stable(sst_q[0])) else $error("stage count stuck");
    and_all_a: assert property (event_w && ctrl_q[CTRL_ALL]
        |-> (sat_q & expr_en_q) == expr_en_q) else $error("AND-all event early");
    final_hold_a: assert property (event_w && ctrl_q[CTRL_FIN_EN] && !clear_w
        && {1'b0, fcnt_q} + 17'h00001 < {1'b0, final_q} |=> !trigger_o) else $error("final count ignored");
    pos_center_a: assert property (fire && pos_q == POS_CENTER
        |=> trig_pos_o == ($past(spt_q) >> 1)) else $error("center position wrong");
    bad_window_a: assert property (cfg_bad |=> !trigger_o) else $error("trigger with oversize window");
    clear_all_a: assert property (clear_w
        |=> sat_q == '0 && tcnt_q == '0 && fcnt_q == '0 && !done_o) else $error("clear incomplete");
    read_ctrl_a: assert property (rd_i && addr_i == A_CTRL
        |=> rdata_o == 32'($past(ctrl_q))) else $error("control readback wrong");

    trig_c: cover property (trigger_o);
    next_seq_c: cover property (strict_q[0] && cond[0] && sst_q[0] == 2'h1);
    done_c: cover property (!done_o ##1 done_o);
endmodule // lta_trigger

// File: lta_host.sv
`timescale 1ns/1ps
// Purpose: host side model that drives the register port of the trigger block
// Assumes: one access at a time, all strobes on the sample clock
// Notes: GAP idle cycles after each access model a slowed cable clock
module lta_host #(
    parameter int GAP = 0
) (
    // Clock
    input  wire logic                       clock_i,
    // Register port
    output logic      [lta_pkg::ADDR_W-1:0] addr_o,
    output logic      [31:0]                wdata_o,
    output logic                            wr_o,
    output logic                            rd_o,
    input  wire logic [31:0]                rdata_i
);
    import lta_pkg::*;
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clock_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
        repeat (GAP) @(posedge clock_i);
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(posedge clock_i);
        d = rdata_i;
        repeat (GAP) @(posedge clock_i);
    endtask
endmodule // lta_host

// File: tb_lta_trigger.sv
`timescale 1ns/1ps
// Purpose: self-checking bench of the trigger engine
// Assumes: the host model owns the register port
// Notes: trigger counts read back judge each run scenario; the position test checks trigger_o, trig_pos_o and done_o directly
module tb_lta_trigger;
    import lta_pkg::*;
    logic                   clock_i  = 1'b0;
    logic                   arst_n_i = 1'b0;
    logic [NUM_TU*TU_W-1:0] probe_i  = '0;
    logic [ADDR_W-1:0]      addr;
    logic [31:0]            wdata, rdata, d;
    logic                   wr, rd, trigger_o, done_o;
    logic [IDX_W-1:0]       trig_pos_o;
    int                     failures = 0, comparisons = 0, seed = 3;
    int                     p0, p1, v, c, e;
    logic [31:0]            sq[$];
    always #20 clock_i = ~clock_i;
    lta_host #(.GAP(1)) i_lta_host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));
    lta_trigger i_lta_trigger (.clock_i(clock_i), .arst_n_i(arst_n_i), .probe_i(probe_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trigger_o(trigger_o), .trig_pos_o(trig_pos_o),
        .done_o(done_o));
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            failures++;
            $display("Error %s expected %h seen %h", n, ex, got);
        end
    endtask
    task automatic rdchk(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] ex);
        i_lta_host.rd_reg(a, d);
        chk(n, ex, d);
    endtask
    // Clear and arm, play sq one sample a clock, then read the trigger count
    task automatic run(input string n, input logic [31:0] pre, input logic [3:0] mode, input int ex);
        probe_i <= pre;
        repeat (2) @(posedge clock_i);
        i_lta_host.wr_reg(A_CTRL, {28'h0, mode} | 32'h9);
        foreach (sq[i]) begin
            @(posedge clock_i);
            probe_i <= sq[i];
        end
        repeat (4) @(posedge clock_i);
        rdchk(n, A_TRIG_CNT, ex);
        $display("Test %s done", n);
    endtask
    function automatic int hit(int op, int v, int c, int a, int b);
        case (op)
            0: return ((a ^ v) & c) == 0;
            1: return ((a ^ v) & c) != 0;
            2: return a > v;
            3: return a >= v;
            4: return a < v;
            5: return a <= v;
            6: return (~a & b & v) != 0;
            default: return (a & ~b & v) != 0;
        endcase
    endfunction
    task automatic results;
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        results();
    end
    initial begin
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        rdchk("ctrl", A_CTRL, 32'h0);
        rdchk("final", A_FINAL, 32'h1);
        rdchk("spt", A_SPT, 32'h80);
        rdchk("ser_len", A_SER_LEN, 32'h4);
        rdchk("care", 10'h048, 32'hFF);
        rdchk("unmapped", 10'h3FC, 32'h0);
        i_lta_host.wr_reg(10'h070, 32'h2);
        rdchk("serial op", 10'h070, 32'h0);
        i_lta_host.wr_reg(A_NTRIG, 32'h10);
        rdchk("window", A_STATUS, 32'h20000);
        $display("Test registers done");
        i_lta_host.wr_reg(A_NTRIG, 32'h1);
        i_lta_host.wr_reg(A_STG_BASE, 32'h0400AAAA);
        i_lta_host.wr_reg(A_EXPR_EN, 32'h1);
        for (int i = 0; i < 24; i++) begin
            p0 = $random(seed) & 255;
            c = $random(seed) & 255;
            v = (p0 ^ ($random(seed) & (i[3] ? ~c : 255))) & 255;
            p1 = (i % 8 < 6) ? p0 : $random(seed) & 255;
            i_lta_host.wr_reg(A_TU_BASE, i % 8);
            i_lta_host.wr_reg(10'h044, v);
            i_lta_host.wr_reg(10'h048, c);
            sq = {p1};
            run("unit op", p0, 4'h0, hit(i % 8, v, c, p0, p1));
        end
        i_lta_host.wr_reg(A_TU_BASE, 32'h0);
        i_lta_host.wr_reg(10'h044, 32'h1);
        i_lta_host.wr_reg(10'h048, 32'hFF);
        for (int m = 0; m < 4; m++) begin
            e = (m == 0) ? 128 / 16 : (m == 1) ? 128 / 2 : (m == 2) ? 128 - 128 / 16 : 127;
            i_lta_host.wr_reg(A_POS, 32'h00C80000 | m);
            probe_i <= '0;
            i_lta_host.wr_reg(A_CTRL, 32'h9);
            @(posedge clock_i);
            probe_i <= 32'h1;
            @(posedge clock_i);
            #1 chk("trigger early", 0, trigger_o);
            @(posedge clock_i);
            #1 chk("trigger", 1, trigger_o);
            chk("position", e, trig_pos_o);
            @(posedge clock_i);
            probe_i <= '0;
            #1 chk("done", 1, done_o);
        end
        $display("Test position done");
        i_lta_host.wr_reg(10'h054, 32'h1);
        i_lta_host.wr_reg(A_STG_BASE + 10'h4, 32'h0600CCCC);
        i_lta_host.wr_reg(A_STG_BASE, 32'h0000AAAA);
        sq = {32'h1, 32'h0, 32'h100, 32'h0};
        run("next gap", 0, 4'h0, 0);
        sq = {32'h1, 32'h100, 32'h0};
        run("next", 0, 4'h0, 1);
        i_lta_host.wr_reg(A_STG_BASE, 32'h0503AAAA);
        sq = {32'h1, 32'h1, 32'h0, 32'h1, 32'h1, 32'h0};
        run("consec gap", 0, 4'h0, 0);
        sq = {32'h1, 32'h1, 32'h1, 32'h0};
        run("consec", 0, 4'h0, 1);
        i_lta_host.wr_reg(A_STG_BASE, 32'h0403AAAA);
        sq = {32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
        run("count", 0, 4'h0, 1);
        i_lta_host.wr_reg(A_STG_BASE, 32'h0400AAAA);
        i_lta_host.wr_reg(A_FINAL, 32'h3);
        sq = {32'h1, 32'h0, 32'h1, 32'h0};
        run("final short", 0, 4'h4, 0);
        sq = {32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
        run("final", 0, 4'h4, 1);
        i_lta_host.wr_reg(A_STG_BASE + 10'h10, 32'h0400CCCC);
        i_lta_host.wr_reg(A_EXPR_EN, 32'h3);
        sq = {32'h1, 32'h0};
        run("and all", 0, 4'h2, 0);
        run("or all", 0, 4'h0, 1);
        i_lta_host.wr_reg(A_EXPR_EN, 32'h1);
        i_lta_host.wr_reg(A_STG_BASE, 32'h0400FF00);
        i_lta_host.wr_reg(10'h074, 32'hB);
        sq = {32'h01000000, 32'h0, 32'h01000000, 32'h01000000, 32'h0};
        run("serial", 0, 4'h0, 1);
        sq = {32'h01000000, 32'h01000000, 32'h0, 32'h01000000, 32'h0};
        run("serial miss", 0, 4'h0, 0);
        // No stage marks itself last, so only the deepest stage can finish
        for (int s = 0; s < SEQ_DEPTH; s++) begin
            i_lta_host.wr_reg(A_STG_BASE + 10'(4 * s), 32'hAAAA);
        end
        sq = {32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
        run("depth short", 0, 4'h0, 0);
        sq.push_back(32'h1);
        run("depth", 0, 4'h0, 1);
        results();
    end
endmodule // tb_lta_trigger
